// ---- sdoc_defines.svh ----
// Register offsets, reset values, field positions and timing counts.
`ifndef SDOC_DEFINES_SVH
`define SDOC_DEFINES_SVH

// ---------------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------------
`define SDOC_REG_RESET 8'h00
`define SDOC_REG_ADDR 8'h01
`define SDOC_REG_STATUS 8'h02
`define SDOC_REG_SWING 8'h27
`define SDOC_REG_TIMING 8'h28

// ---------------------------------------------------------------------------
// Reset values and fields
// ---------------------------------------------------------------------------
`define SDOC_SWING_RST 8'h00
`define SDOC_TIMING_RST 8'h00
`define SDOC_DEVADDR_RST 7'h2A
`define SDOC_SWING_BIG_BIT 0
`define SDOC_TIM_SKEW_LSB 0
`define SDOC_TIM_SKEW_MSB 1
`define SDOC_TIM_HALF_BIT 2
`define SDOC_STAT_LOCK_BIT 0
`define SDOC_STAT_FRAMED_BIT 1

// ---------------------------------------------------------------------------
// Timing and framing
// ---------------------------------------------------------------------------
`define SDOC_CLK_NS 10
`define SDOC_RELOCK_US 5000
`define SDOC_FRAME_KCHARS 110
`define SDOC_COMMA_NEG 10'h17C
`define SDOC_COMMA_POS 10'h283
`define SDOC_CHAR_LAST 4'h9
`define SDOC_HI_PHASE 4'h5
`define SDOC_RISE_BASE 4'h1
`define SDOC_FALL_BASE 4'h6
`define SDOC_BIT_NONE 4'hF
`define SDOC_BIT_ACK 4'h8
`define SDOC_BIT_LAST 4'h7

`endif

// ---- sdoc_deser.sv ----
// Serial video deserializer control, register slave and output bus logic.
`timescale 1ns/10ps
`include "sdoc_defines.svh"

module sdoc_deser import sdoc_pkg::*; #(
	parameter int unsigned RELOCK_CYC =
		(`SDOC_RELOCK_US * 1000) / `SDOC_CLK_NS, // Relock hold in cycles.
	parameter int unsigned FRAME_KCHARS = `SDOC_FRAME_KCHARS // Commas needed.
) (
	input wire logic ref_clk, // Core clock, 100 MHz.
	input wire logic rst_n, // Reset pin, asynchronous, active low.
	input wire logic rec_clk, // Recovered bit clock of the link.
	input wire logic primary_serial_input, // Serial input 0.
	input wire logic secondary_serial_input, // Serial input 1.
	input wire logic input_select_pin, // High selects serial input 1.
	input wire logic asi_mode_pin, // High engages framer and decoder.
	input wire logic pll_lock_pin, // Recovery loop lock from analog side.
	input wire logic smb_cs, // Management bus chip select, high.
	input wire logic smb_scl, // Management bus clock.
	input wire logic smb_sda_in, // Management bus data level.
	output logic smb_sda_out, // Data drive level, always low.
	output logic smb_sda_oe, // High while pulling data low.
	output logic loopthrough_out, // Retimed serial loopthrough.
	output logic lock_loss, // High while unlocked.
	output logic large_swing, // High selects large output swing.
	output logic output_word_clock, // Output bus clock.
	output logic [3:0] decoded_nibble_lines, // Output data lines.
	output logic idle_char_flag // Idle nibble flag.
);

	localparam int RCW = $clog2(RELOCK_CYC + 1);

	// Refuse counts that the counters cannot hold.
	if (RELOCK_CYC < 1 || FRAME_KCHARS < 1 || FRAME_KCHARS > 127) begin : g_chk
		$error("sdoc_deser: unsupported parameter value");
	end

	// -----------------------------------------------------------------------
	// Management bus slave
	// -----------------------------------------------------------------------
	logic [2:0] scl_sy_ff, sda_sy_ff;
	logic [1:0] cs_sy_ff;
	sdoc_smb_state_t smb_state_ff;
	logic [3:0] bit_ff;
	logic [7:0] shift_ff, ptr_ff;
	logic mack_ff, oe_ff;
	logic [6:0] dev_addr_ff;
	logic [7:0] swing_ff, timing_ff;
	logic soft_rst_ff, lock_loss_ff, framed_core, framed_ff, framed_tx_ff;
	logic [1:0] framed_sy_ff;
	logic scl_rise, scl_fall, bus_start, bus_stop, wr_en;
	logic [7:0] rd_cur, rd_nxt;

	// Register read decode, used for the first and the following bytes.
	function automatic logic [7:0] reg_read(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			`SDOC_REG_ADDR: v = {1'b0, dev_addr_ff};
			`SDOC_REG_STATUS: begin
				v[`SDOC_STAT_LOCK_BIT] = ~lock_loss_ff;
				v[`SDOC_STAT_FRAMED_BIT] = framed_core;
			end
			`SDOC_REG_SWING: v = swing_ff;
			`SDOC_REG_TIMING: v = timing_ff;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : reg_read

	// Read data for the current and the next pointer, ready before each load.
	always_comb begin
		rd_cur = reg_read(ptr_ff);
		rd_nxt = reg_read(ptr_ff + 8'h01);
	end

	// Bus pins are asynchronous; only second and third stages are read.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sy_ff <= 3'h7;
			sda_sy_ff <= 3'h7;
			cs_sy_ff <= 2'h0;
		end else begin
			scl_sy_ff <= {scl_sy_ff[1:0], smb_scl};
			sda_sy_ff <= {sda_sy_ff[1:0], smb_sda_in};
			cs_sy_ff <= {cs_sy_ff[0], smb_cs};
		end
	end

	assign scl_rise = scl_sy_ff[1] & ~scl_sy_ff[2];
	assign scl_fall = ~scl_sy_ff[1] & scl_sy_ff[2];
	assign bus_start = scl_sy_ff[1] & scl_sy_ff[2] & sda_sy_ff[2] & ~sda_sy_ff[1];
	assign bus_stop = scl_sy_ff[1] & scl_sy_ff[2] & ~sda_sy_ff[2] & sda_sy_ff[1];
	assign wr_en = cs_sy_ff[1] & scl_fall & (bit_ff == `SDOC_BIT_ACK) &
		(smb_state_ff == smb_wr);

	// Byte engine: address, register pointer, write data, read data.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			smb_state_ff <= smb_idle;
			bit_ff <= `SDOC_BIT_NONE;
			shift_ff <= 8'h00;
			ptr_ff <= 8'h00;
			mack_ff <= 1'b0;
			oe_ff <= 1'b0;
		end else if (bus_stop || !cs_sy_ff[1]) begin
			smb_state_ff <= smb_idle;
			oe_ff <= 1'b0;
		end else if (bus_start) begin
			smb_state_ff <= smb_dev;
			bit_ff <= `SDOC_BIT_NONE;
			oe_ff <= 1'b0;
		end else if (scl_rise && bit_ff <= `SDOC_BIT_LAST) begin
			if (smb_state_ff != smb_rd) begin
				shift_ff <= {shift_ff[6:0], sda_sy_ff[1]};
			end
		end else if (scl_rise && bit_ff == `SDOC_BIT_ACK) begin
			mack_ff <= sda_sy_ff[1];
		end else if (scl_fall) begin
			if (bit_ff == `SDOC_BIT_NONE) begin
				bit_ff <= 4'h0;
			end else if (bit_ff == `SDOC_BIT_LAST) begin
				bit_ff <= `SDOC_BIT_ACK;
				if (smb_state_ff == smb_rd) begin
					oe_ff <= 1'b0;
				end else if (smb_state_ff == smb_dev &&
					shift_ff[7:1] != dev_addr_ff) begin
					smb_state_ff <= smb_idle;
				end else if (smb_state_ff != smb_idle) begin
					oe_ff <= 1'b1;
				end
			end else if (bit_ff == `SDOC_BIT_ACK) begin
				bit_ff <= 4'h0;
				oe_ff <= 1'b0;
				unique case (smb_state_ff)
					smb_dev: begin
						if (shift_ff[0]) begin
							smb_state_ff <= smb_rd;
							shift_ff <= rd_cur;
							oe_ff <= ~rd_cur[7];
						end else begin
							smb_state_ff <= smb_reg;
						end
					end
					smb_reg: begin
						ptr_ff <= shift_ff;
						smb_state_ff <= smb_wr;
					end
					smb_wr: ptr_ff <= ptr_ff + 8'h01; // Pointer auto-increments.
					smb_rd: begin
						if (!mack_ff) begin
							ptr_ff <= ptr_ff + 8'h01;
							shift_ff <= rd_nxt;
							oe_ff <= ~rd_nxt[7];
						end else begin
							smb_state_ff <= smb_idle;
						end
					end
					smb_idle: ;
				endcase
			end else begin
				bit_ff <= bit_ff + 4'h1;
				if (smb_state_ff == smb_rd) begin
					shift_ff <= {shift_ff[6:0], 1'b0};
					oe_ff <= ~shift_ff[6];
				end
			end
		end
	end

	assign smb_sda_out = 1'b0;
	assign smb_sda_oe = oe_ff;

	// -----------------------------------------------------------------------
	// Control registers
	// -----------------------------------------------------------------------
	// Soft reset reverts the output controls; the bus address survives it.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_rst_ff <= 1'b0;
			swing_ff <= `SDOC_SWING_RST;
			timing_ff <= `SDOC_TIMING_RST;
		end else if (soft_rst_ff) begin
			soft_rst_ff <= 1'b0;
			swing_ff <= `SDOC_SWING_RST;
			timing_ff <= `SDOC_TIMING_RST;
		end else begin
			soft_rst_ff <= wr_en && ptr_ff == `SDOC_REG_RESET;
			if (wr_en && ptr_ff == `SDOC_REG_SWING) begin
				swing_ff <= shift_ff;
			end
			if (wr_en && ptr_ff == `SDOC_REG_TIMING) begin
				timing_ff <= shift_ff;
			end
		end
	end

	// Only the pin reset may return the bus address to its default.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dev_addr_ff <= `SDOC_DEVADDR_RST;
		end else if (wr_en && ptr_ff == `SDOC_REG_ADDR) begin
			dev_addr_ff <= shift_ff[6:0];
		end
	end

	assign large_swing = swing_ff[`SDOC_SWING_BIG_BIT];

	// -----------------------------------------------------------------------
	// Lock reporting
	// -----------------------------------------------------------------------
	logic [1:0] pll_sy_ff;
	logic [RCW-1:0] relock_cnt_ff;

	// Lock is reported only after the loop has held lock for the hold time.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pll_sy_ff <= 2'h0;
			relock_cnt_ff <= '0;
			lock_loss_ff <= 1'b1;
		end else begin
			pll_sy_ff <= {pll_sy_ff[0], pll_lock_pin};
			if (!pll_sy_ff[1] || soft_rst_ff) begin
				relock_cnt_ff <= '0;
			end else if (relock_cnt_ff != RCW'(RELOCK_CYC)) begin
				relock_cnt_ff <= relock_cnt_ff + RCW'(1);
			end
			lock_loss_ff <= !(pll_sy_ff[1] && !soft_rst_ff &&
				relock_cnt_ff == RCW'(RELOCK_CYC));
		end
	end

	assign lock_loss = lock_loss_ff;

	// Framing state back from the link domain, for the status register.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			framed_sy_ff <= 2'h0;
		end else begin
			framed_sy_ff <= {framed_sy_ff[0], framed_tx_ff};
		end
	end

	assign framed_core = framed_sy_ff[1];

	// -----------------------------------------------------------------------
	// Link domain: input select, loopthrough, framing and output bus
	// -----------------------------------------------------------------------
	logic rec_arst_n;
	logic [1:0] rec_rst_ff, pri_sy_ff, sec_sy_ff, sel_sy_ff, asi_sy_ff;
	sdoc_link_cfg_t cfg_s1_ff, cfg_s2_ff;
	logic loop_ff, bit_now, comma_now, wrap, out_ok, oclk_ff;
	logic [9:0] sh_ff, word_ff, nxt_sh;
	logic [7:0] byte_ff;
	logic idle_ff;
	logic [3:0] ph_ff, rise_ph, fall_ph;
	logic [6:0] kcnt_ff;
	sdoc_out_bus_t out_ff;

	// 8b10b decode of one character, bit a held in bit 0.
	function automatic logic [7:0] dec_char(input logic [9:0] w);
		logic [5:0] s6;
		logic [3:0] f4;
		logic [4:0] lo;
		logic [2:0] hi;
		s6 = {w[0], w[1], w[2], w[3], w[4], w[5]};
		f4 = {w[6], w[7], w[8], w[9]};
		case (s6)
			6'h27, 6'h18: lo = 5'h00;
			6'h1D, 6'h22: lo = 5'h01;
			6'h2D, 6'h12: lo = 5'h02;
			6'h31: lo = 5'h03;
			6'h35, 6'h0A: lo = 5'h04;
			6'h29: lo = 5'h05;
			6'h19: lo = 5'h06;
			6'h38, 6'h07: lo = 5'h07;
			6'h39, 6'h06: lo = 5'h08;
			6'h25: lo = 5'h09;
			6'h15: lo = 5'h0A;
			6'h34: lo = 5'h0B;
			6'h0D: lo = 5'h0C;
			6'h2C: lo = 5'h0D;
			6'h1C: lo = 5'h0E;
			6'h17, 6'h28: lo = 5'h0F;
			6'h1B, 6'h24: lo = 5'h10;
			6'h23: lo = 5'h11;
			6'h13: lo = 5'h12;
			6'h32: lo = 5'h13;
			6'h0B: lo = 5'h14;
			6'h2A: lo = 5'h15;
			6'h1A: lo = 5'h16;
			6'h3A, 6'h05: lo = 5'h17;
			6'h33, 6'h0C: lo = 5'h18;
			6'h26: lo = 5'h19;
			6'h16: lo = 5'h1A;
			6'h36, 6'h09: lo = 5'h1B;
			6'h0E, 6'h0F, 6'h30: lo = 5'h1C;
			6'h2E, 6'h11: lo = 5'h1D;
			6'h1E, 6'h21: lo = 5'h1E;
			6'h2B, 6'h14: lo = 5'h1F;
			default: lo = 5'h00;
		endcase
		case (f4)
			4'hB, 4'h4: hi = 3'h0;
			4'h9: hi = 3'h1;
			4'h5: hi = 3'h2;
			4'hC, 4'h3: hi = 3'h3;
			4'hD, 4'h2: hi = 3'h4;
			4'hA: hi = 3'h5;
			4'h6: hi = 3'h6;
			4'hE, 4'h1, 4'h7, 4'h8: hi = 3'h7;
			default: hi = 3'h0;
		endcase
		return {hi, lo};
	endfunction : dec_char

	// Either reset clears the link side; release is retimed to rec_clk.
	assign rec_arst_n = rst_n & ~soft_rst_ff;

	always_ff @(posedge rec_clk or negedge rec_arst_n) begin
		if (!rec_arst_n) begin
			rec_rst_ff <= 2'h0;
		end else begin
			rec_rst_ff <= {rec_rst_ff[0], 1'b1};
		end
	end

	// Pins and slow controls pass two flops before use on the link side.
	always_ff @(posedge rec_clk or negedge rec_rst_ff[1]) begin
		if (!rec_rst_ff[1]) begin
			pri_sy_ff <= 2'h0;
			sec_sy_ff <= 2'h0;
			sel_sy_ff <= 2'h0;
			asi_sy_ff <= 2'h0;
			cfg_s1_ff <= '0;
			cfg_s2_ff <= '0;
		end else begin
			pri_sy_ff <= {pri_sy_ff[0], primary_serial_input};
			sec_sy_ff <= {sec_sy_ff[0], secondary_serial_input};
			sel_sy_ff <= {sel_sy_ff[0], input_select_pin};
			asi_sy_ff <= {asi_sy_ff[0], asi_mode_pin};
			cfg_s1_ff <= {~lock_loss_ff, timing_ff[`SDOC_TIM_HALF_BIT],
				timing_ff[`SDOC_TIM_SKEW_MSB:`SDOC_TIM_SKEW_LSB]};
			cfg_s2_ff <= cfg_s1_ff;
		end
	end

	// Switching inputs may realign phase and corrupt a few words.
	assign bit_now = sel_sy_ff[1] ? sec_sy_ff[1] : pri_sy_ff[1];
	assign nxt_sh = {bit_now, sh_ff[9:1]};
	assign comma_now = nxt_sh == `SDOC_COMMA_NEG || nxt_sh == `SDOC_COMMA_POS;
	assign wrap = ph_ff == `SDOC_CHAR_LAST || (asi_sy_ff[1] && comma_now);
	assign framed_ff = kcnt_ff == 7'(FRAME_KCHARS);
	assign out_ok = cfg_s2_ff.lock_ok && (!asi_sy_ff[1] || framed_ff);
	assign rise_ph = `SDOC_RISE_BASE + {2'h0, cfg_s2_ff.skew};
	assign fall_ph = `SDOC_FALL_BASE + {2'h0, cfg_s2_ff.skew};

	// Character assembly; a comma realigns the boundary in decode mode.
	always_ff @(posedge rec_clk or negedge rec_rst_ff[1]) begin
		if (!rec_rst_ff[1]) begin
			loop_ff <= 1'b0;
			sh_ff <= 10'h000;
			ph_ff <= 4'h0;
			word_ff <= 10'h000;
			byte_ff <= 8'h00;
			idle_ff <= 1'b1;
		end else begin
			loop_ff <= bit_now;
			sh_ff <= nxt_sh;
			ph_ff <= wrap ? 4'h0 : ph_ff + 4'h1;
			if (wrap) begin
				word_ff <= nxt_sh;
				byte_ff <= dec_char(nxt_sh);
				idle_ff <= comma_now;
			end
		end
	end

	// Counts aligned commas in a row; a misplaced one restarts the count.
	always_ff @(posedge rec_clk or negedge rec_rst_ff[1]) begin
		if (!rec_rst_ff[1]) begin
			kcnt_ff <= 7'h00;
		end else if (!asi_sy_ff[1] || !cfg_s2_ff.lock_ok) begin
			kcnt_ff <= 7'h00;
		end else if (wrap) begin
			if (comma_now && ph_ff != `SDOC_CHAR_LAST) begin
				kcnt_ff <= 7'h01;
			end else if (comma_now && !framed_ff) begin
				kcnt_ff <= kcnt_ff + 7'h01;
			end else if (!comma_now && !framed_ff) begin
				kcnt_ff <= 7'h00;
			end
		end
	end

	// Registered copy for the core side, so no decode glitch crosses over.
	always_ff @(posedge rec_clk or negedge rec_rst_ff[1]) begin
		if (!rec_rst_ff[1]) begin
			framed_tx_ff <= 1'b0;
		end else begin
			framed_tx_ff <= framed_ff;
		end
	end

	// Low half goes out at phase 0, high half at the middle phase.
	always_ff @(posedge rec_clk or negedge rec_rst_ff[1]) begin
		if (!rec_rst_ff[1]) begin
			out_ff <= '{idle: 1'b1, nib: 4'h0};
		end else if (!out_ok) begin
			out_ff <= '{idle: 1'b1, nib: 4'h0};
		end else if (ph_ff == 4'h0) begin
			out_ff <= asi_sy_ff[1] ? {idle_ff, byte_ff[3:0]} : word_ff[4:0];
		end else if (ph_ff == `SDOC_HI_PHASE) begin
			out_ff <= asi_sy_ff[1] ? {idle_ff, byte_ff[7:4]} : word_ff[9:5];
		end
	end

	// Clock rises on the low half and falls on the high half, or toggles.
	always_ff @(posedge rec_clk or negedge rec_rst_ff[1]) begin
		if (!rec_rst_ff[1]) begin
			oclk_ff <= 1'b0;
		end else if (!out_ok) begin
			oclk_ff <= 1'b0;
		end else if (cfg_s2_ff.half_rate) begin
			if (ph_ff == rise_ph) begin
				oclk_ff <= ~oclk_ff;
			end
		end else if (ph_ff == rise_ph) begin
			oclk_ff <= 1'b1;
		end else if (ph_ff == fall_ph) begin
			oclk_ff <= 1'b0;
		end
	end

	assign loopthrough_out = loop_ff;
	assign output_word_clock = oclk_ff;
	assign decoded_nibble_lines = out_ff.nib;
	assign idle_char_flag = out_ff.idle;

	// -----------------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------------
	property p_soft_defaults;
		@(posedge ref_clk) disable iff (!rst_n)
		soft_rst_ff |=> swing_ff == `SDOC_SWING_RST && timing_ff == `SDOC_TIMING_RST;
	endproperty
	a_soft_defaults: assert property (p_soft_defaults)
		else $error("soft reset left output controls changed");

	property p_addr_kept;
		@(posedge ref_clk) disable iff (!rst_n)
		soft_rst_ff |=> $stable(dev_addr_ff);
	endproperty
	a_addr_kept: assert property (p_addr_kept)
		else $error("soft reset changed the bus address");

	property p_swing_default;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> !large_swing;
	endproperty
	a_swing_default: assert property (p_swing_default)
		else $error("large swing selected after reset");

	property p_unlock_fast;
		@(posedge ref_clk) disable iff (!rst_n)
		!pll_sy_ff[1] |=> lock_loss;
	endproperty
	a_unlock_fast: assert property (p_unlock_fast)
		else $error("lock loss not shown");

	property p_relock_hold;
		@(posedge ref_clk) disable iff (!rst_n)
		$fell(lock_loss) |-> $past(relock_cnt_ff) == RCW'(RELOCK_CYC);
	endproperty
	a_relock_hold: assert property (p_relock_hold)
		else $error("lock regained before hold time");

	property p_inactive;
		@(posedge rec_clk) disable iff (!rec_rst_ff[1])
		!out_ok |=> idle_char_flag && decoded_nibble_lines == 4'h0 && !oclk_ff;
	endproperty
	a_inactive: assert property (p_inactive)
		else $error("output bus active without lock");

	property p_low_nibble;
		@(posedge rec_clk) disable iff (!rec_rst_ff[1])
		ph_ff == 4'h0 && out_ok && asi_sy_ff[1] |=>
			decoded_nibble_lines == $past(byte_ff[3:0]) &&
			idle_char_flag == $past(idle_ff);
	endproperty
	a_low_nibble: assert property (p_low_nibble)
		else $error("low nibble or idle flag wrong");

	property p_high_nibble;
		@(posedge rec_clk) disable iff (!rec_rst_ff[1])
		ph_ff == `SDOC_HI_PHASE && out_ok && asi_sy_ff[1] |=>
			decoded_nibble_lines == $past(byte_ff[7:4]);
	endproperty
	a_high_nibble: assert property (p_high_nibble)
		else $error("high nibble wrong");

	property p_framed;
		@(posedge rec_clk) disable iff (!rec_rst_ff[1])
		$rose(framed_ff) |-> $past(kcnt_ff) == 7'(FRAME_KCHARS - 1);
	endproperty
	a_framed: assert property (p_framed)
		else $error("framed before enough commas");

	property p_loop;
		@(posedge rec_clk) disable iff (!rec_rst_ff[1])
		sel_sy_ff[1] |=> loopthrough_out == $past(sec_sy_ff[1]);
	endproperty
	a_loop: assert property (p_loop)
		else $error("loopthrough not from selected input");

	c_relock: cover property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(lock_loss));
	c_soft: cover property (@(posedge ref_clk) disable iff (!rst_n)
		soft_rst_ff);
	c_framed: cover property (@(posedge rec_clk) disable iff (!rec_rst_ff[1])
		$rose(framed_ff));

endmodule : sdoc_deser

// ---- sdoc_deser_tb.sv ----
// Self-checking bench for the deserializer output control block.
`timescale 1ns/10ps
module sdoc_deser_tb import sdoc_pkg::*; ();
	// ------
	// Setup
	// ------
	localparam int RLK = 20;
	localparam int FK = 4;
	logic ref_clk = 0, rec_clk = 0, rst_n = 0;
	logic pri = 0, sec = 0, sel = 0, asi = 0, pll = 0;
	logic scl = 1, hsda = 1, rd = 0;
	logic sda_out, sda_oe, lt, loss, big, owc, idle;
	logic [3:0] nib;
	int error_cnt = 0, tests_run = 0, e0;
	// Open-drain data wire: either party may pull it low.
	wire sda = hsda & ~sda_oe;
	initial forever #5 ref_clk = ~ref_clk;
	// Link clock, unrelated in phase to the core clock.
	initial begin
		#3;
		forever #32 rec_clk = ~rec_clk;
	end
	sdoc_deser #(.RELOCK_CYC(RLK), .FRAME_KCHARS(FK)) sdoc_deser_i (
		.ref_clk(ref_clk), .rst_n(rst_n), .rec_clk(rec_clk),
		.primary_serial_input(pri), .secondary_serial_input(sec),
		.input_select_pin(sel), .asi_mode_pin(asi), .pll_lock_pin(pll),
		.smb_cs(1'b1), .smb_scl(scl), .smb_sda_in(sda),
		.smb_sda_out(sda_out), .smb_sda_oe(sda_oe), .loopthrough_out(lt),
		.lock_loss(loss), .large_swing(big), .output_word_clock(owc),
		.decoded_nibble_lines(nib), .idle_char_flag(idle));
	sdoc_host sdoc_host_i (.output_word_clock(owc),
		.decoded_nibble_lines(nib), .idle_char_flag(idle));
	// ------
	// Tasks
	// ------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic finish_test;
		$display("Checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	// Bounded wait on the lock flag; a lapse ends the run.
	task automatic wait_loss(input logic v, input int n);
		for (int i = 0; i < n && loss !== v; i++)
			cyc(1);
		chk(loss, v);
		if (loss !== v) begin
			finish_test();
		end
	endtask : wait_loss
	// One character on the primary input, bit 0 first.
	task automatic send(input logic [9:0] c);
		for (int i = 0; i < 10; i++) begin
			@(negedge rec_clk);
			pri = c[i];
		end
	endtask : send
	// Commas alternate so the running disparity stays legal.
	task automatic send_k;
		send(rd ? 10'h283 : 10'h17C);
		rd = ~rd;
	endtask : send_k
	// Bus phases are kept well above four core cycles.
	task automatic smb_bit(input logic b);
		hsda = b;
		cyc(6);
		scl = 1;
		cyc(6);
		scl = 0;
		cyc(2);
	endtask : smb_bit
	task automatic smb_byte(input logic [7:0] d, input logic ck);
		for (int i = 7; i >= 0; i--)
			smb_bit(d[i]);
		hsda = 1;
		cyc(6);
		if (ck) begin
			chk(sda_oe, 1'b1);
		end
		scl = 1;
		cyc(6);
		scl = 0;
		cyc(2);
	endtask : smb_byte
	task automatic smb_wr(input logic [6:0] a, input logic [7:0] r, d);
		hsda = 0;
		cyc(6);
		scl = 0;
		cyc(2);
		smb_byte({a, 1'b0}, 1'b1);
		smb_byte(r, 1'b1);
		smb_byte(d, 1'b1);
		hsda = 0;
		cyc(6);
		scl = 1;
		cyc(6);
		hsda = 1;
		cyc(6);
	endtask : smb_wr
	// Register read: pointer write, repeated start, one byte, master NACK.
	task automatic smb_rd(input logic [6:0] a, input logic [7:0] r,
		output logic [7:0] v);
		hsda = 0;
		cyc(6);
		scl = 0;
		cyc(2);
		smb_byte({a, 1'b0}, 1'b1);
		smb_byte(r, 1'b1);
		cyc(6);
		scl = 1;
		cyc(6);
		hsda = 0;
		cyc(6);
		scl = 0;
		cyc(2);
		smb_byte({a, 1'b1}, 1'b1);
		for (int i = 7; i >= 0; i--) begin
			cyc(6);
			scl = 1;
			cyc(3);
			v[i] = sda;
			cyc(3);
			scl = 0;
			cyc(2);
		end
		smb_bit(1'b1);
		hsda = 0;
		cyc(6);
		scl = 1;
		cyc(6);
		hsda = 1;
		cyc(6);
	endtask : smb_rd
	// ------
	// Scenarios
	// ------
	task automatic t_reset;
		cyc(6);
		chk(loss, 1'b1);
		chk({big, owc}, 8'h00);
		chk({idle, nib}, 8'h10);
		chk({sda_out, sda_oe}, 8'h00);
		rst_n = 1;
		cyc(3);
		$display("Test reset done");
	endtask : t_reset
	task automatic t_lock;
		pll = 1;
		cyc(RLK);
		chk(loss, 1'b1);
		wait_loss(0, 20);
		pll = 0;
		wait_loss(1, 5);
		pll = 1;
		wait_loss(0, RLK + 20);
		$display("Test lock done");
	endtask : t_lock
	// A moved device address must survive the soft reset.
	task automatic t_regs;
		logic [7:0] rv;
		smb_wr(7'h2A, 8'h27, 8'h01);
		chk(big, 1'b1);
		smb_rd(7'h2A, 8'h27, rv);
		chk(rv, 8'h01);
		smb_wr(7'h2A, 8'h01, 8'h15);
		smb_wr(7'h15, 8'h00, 8'h00);
		chk(big, 1'b0);
		smb_rd(7'h15, 8'h01, rv);
		chk(rv, 8'h15);
		smb_wr(7'h15, 8'h27, 8'h01);
		chk(big, 1'b1);
		rst_n = 0;
		cyc(3);
		chk(big, 1'b0);
		rst_n = 1;
		cyc(3);
		smb_wr(7'h2A, 8'h27, 8'h01);
		chk(big, 1'b1);
		$display("Test registers done");
	endtask : t_regs
	task automatic t_loop;
		@(negedge rec_clk);
		pri = 1;
		sel = 1;
		repeat (6) @(negedge rec_clk);
		chk(lt, 1'b0);
		sel = 0;
		repeat (6) @(negedge rec_clk);
		chk(lt, 1'b1);
		repeat (24) @(negedge rec_clk);
		chk({idle, nib}, 8'h1F);
		$display("Test loopthrough done");
	endtask : t_loop
	// Bytes 8'hB5 and 8'h4A have distinct halves, exposing nibble order.
	task automatic t_asi;
		logic [7:0] rv;
		wait_loss(0, RLK + 20);
		asi = 1;
		repeat (2 * FK + 4) send_k();
		sdoc_host_i.got.delete();
		send(10'h155);
		send(10'h2AA);
		repeat (4) send_k();
		chk(8'(sdoc_host_i.got.size()), 8'h02);
		chk(sdoc_host_i.got[0], 8'hB5);
		chk(sdoc_host_i.got[1], 8'h4A);
		chk(sdoc_host_i.idle_cnt > 0, 1'b1);
		e0 = sdoc_host_i.edges;
		repeat (4) send_k();
		chk(8'(sdoc_host_i.edges - e0), 8'h08);
		fork
			smb_wr(7'h2A, 8'h28, 8'h04);
			repeat (12) send_k();
		join
		e0 = sdoc_host_i.edges;
		repeat (4) send_k();
		chk(8'(sdoc_host_i.edges - e0), 8'h04);
		smb_rd(7'h2A, 8'h02, rv);
		chk(rv, 8'h03);
		$display("Test decoder done");
	endtask : t_asi
	initial begin
		t_reset();
		t_lock();
		t_regs();
		t_loop();
		t_asi();
		finish_test();
	end
endmodule : sdoc_deser_tb

// ---- sdoc_host.sv ----
// Host-side model that rebuilds bytes from the five-line output bus.
`timescale 1ns/10ps
module sdoc_host import sdoc_pkg::*; (
	input wire logic output_word_clock, // Output bus clock.
	input wire logic [3:0] decoded_nibble_lines, // Data lines.
	input wire logic idle_char_flag // Idle nibble flag.
);
	// ------
	// Capture
	// ------
	sdoc_out_bus_t lo_q;
	logic [7:0] got[$];
	int idle_cnt = 0;
	int edges = 0;
	// Every clock edge is counted, so the rate mode can be measured.
	always @(output_word_clock) begin
		edges++;
	end
	// The low half of a byte lands on the rising edge.
	always @(posedge output_word_clock) begin
		lo_q = {idle_char_flag, decoded_nibble_lines};
		if (idle_char_flag) begin
			idle_cnt++;
		end
	end
	// Idle halves act as a write inhibit, as a real receive buffer would.
	always @(negedge output_word_clock) begin
		if (!lo_q.idle && !idle_char_flag) begin
			got.push_back({decoded_nibble_lines, lo_q.nib});
		end
	end
endmodule : sdoc_host

// ---- sdoc_pkg.sv ----
// Types shared by the deserializer output control block.
package sdoc_pkg;

	// Management bus slave states.
	typedef enum logic [2:0] {
		smb_idle,
		smb_dev,
		smb_reg,
		smb_wr,
		smb_rd
	} sdoc_smb_state_t;

	// One half-character slot of the five-line output bus.
	typedef struct packed {
		logic idle;
		logic [3:0] nib;
	} sdoc_out_bus_t;

	// Lock state and output timing control fields as seen by the link domain.
	typedef struct packed {
		logic lock_ok;
		logic half_rate;
		logic [1:0] skew;
	} sdoc_link_cfg_t;

endpackage : sdoc_pkg
